// ### verilog/dch_pkg.sv
// constants, types and functions shared by the daisy-chain packet handler
`default_nettype none

package dch_pkg;

   // ==========================================================
   // command codes
   localparam logic [7:0] CMD_ENUMERATE = 8'h57;
   localparam logic [7:0] CMD_BCAST_WRITE = 8'h02;
   localparam logic [7:0] CMD_BCAST_READ = 8'h03;
   localparam logic [2:0] CMD_UNI_WRITE_LOW = 3'h4;
   localparam logic [2:0] CMD_UNI_READ_LOW = 3'h5;

   // ==========================================================
   // byte positions within a packet, command byte is index 0
   localparam logic [7:0] IDX_CMD = 8'h00;
   localparam logic [7:0] IDX_REG = 8'h01;
   localparam logic [7:0] IDX_LSB = 8'h02;
   localparam logic [7:0] IDX_MSB = 8'h03;
   localparam logic [7:0] IDX_WR_PEC = 8'h04;
   localparam logic [7:0] IDX_ENUM_ADDR = 8'h02;
   localparam logic [7:0] ENUM_LEN = 8'h03;
   localparam logic [7:0] IDX_NONE = 8'hff;
   localparam logic [7:0] INSERT_SHIFT = 8'h02;

   // ==========================================================
   // data-check byte bit positions
   localparam int DC_BIT_PEC = 7;
   localparam int DC_BIT_FMEA = 6;
   localparam int DC_BIT_STATUS = 5;
   localparam int DC_BIT_OV = 2;
   localparam int DC_BIT_UV = 1;

   // ==========================================================
   // reset values and check-byte arithmetic
   localparam logic [4:0] RST_DEVICE_ADDRESS = 5'h00;
   localparam logic RST_ADDRESS_UNLOCK = 1'b1;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [7:0] CRC_POLY_DEFAULT = 8'h07;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      FR_IDLE = 3'b001,
      FR_CMD = 3'b010,
      FR_BODY = 3'b100
   } dch_frame_t;

   typedef enum logic [3:0] {
      MD_PASS = 4'b0001,
      MD_WRITE = 4'b0010,
      MD_READ = 4'b0100,
      MD_ENUM = 4'b1000
   } dch_mode_t;

   // ==========================================================
   // one byte of crc-8, msb first
   function automatic logic [7:0] dch_crc8_byte(input logic [7:0] crc, input logic [7:0] din,
                                                input logic [7:0] poly);
      logic [7:0] c;
      c = crc ^ din;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ poly) : (c << 1);
      end
      return c;
   endfunction

endpackage

`default_nettype wire

// ### verilog/dch_crc8.sv
// running crc-8 accumulator over a byte stream
`default_nettype none

module dch_crc8 import dch_pkg::*; #(
   parameter logic [7:0] POLY = CRC_POLY_DEFAULT
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clear,
   input wire logic step,
   input wire logic [7:0] din,
   output logic [7:0] crc
);

   // ==========================================================
   // accumulator
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         crc <= CRC_INIT;
      end else if (clear) begin
         crc <= CRC_INIT;
      end else if (step) begin
         crc <= dch_crc8_byte(crc, din, POLY);
      end
   end

endmodule

`default_nettype wire

// ### verilog/dch_status.sv
// sticky check-error alert and data-check status summary
`default_nettype none

module dch_status import dch_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic failure_mode_alert_one,
   input wire logic failure_mode_alert_two,
   input wire logic overvoltage_alert,
   input wire logic undervoltage_alert,
   input wire logic other_status_alert,
   input wire logic pec_error,
   input wire logic check_error_alert_clear,
   output logic check_error_alert,
   output logic [7:0] summary
);

   // ==========================================================
   // sticky alert, set wins over clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         check_error_alert <= 1'b0;
      end else if (pec_error) begin
         check_error_alert <= 1'b1;
      end else if (check_error_alert_clear) begin
         check_error_alert <= 1'b0;
      end
   end

   // ==========================================================
   // summary bits, unused bits 0, 3 and 4 stay zero so they forward
   always_comb begin
      summary = 8'h00;
      summary[DC_BIT_PEC] = check_error_alert;
      summary[DC_BIT_FMEA] = failure_mode_alert_one | failure_mode_alert_two;
      summary[DC_BIT_STATUS] = other_status_alert | check_error_alert;
      summary[DC_BIT_OV] = overvoltage_alert;
      summary[DC_BIT_UV] = undervoltage_alert;
   end

endmodule

`default_nettype wire

// ### verilog/dch_packet_handler.sv
// packet handler for one device in a daisy-chained byte link
`default_nettype none

module dch_packet_handler import dch_pkg::*; #(
   parameter logic [7:0] CRC_POLY = CRC_POLY_DEFAULT
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_preamble,
   input wire logic rx_stop,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_preamble,
   output logic tx_stop,
   input wire logic upstack_path,
   input wire logic alive_counter_enable,
   input wire logic check_bypass,
   input wire logic [4:0] first_address_field,
   input wire logic address_unlock_set,
   input wire logic failure_mode_alert_one,
   input wire logic failure_mode_alert_two,
   input wire logic overvoltage_alert,
   input wire logic undervoltage_alert,
   input wire logic other_status_alert,
   input wire logic check_error_alert_clear,
   output logic [7:0] reg_addr,
   input wire logic reg_addr_ok,
   input wire logic [15:0] reg_rd_data,
   output logic reg_wr_en,
   output logic [15:0] reg_wr_data,
   output logic [4:0] device_address_field,
   output logic address_unlock,
   output logic check_error_alert
);

   // ==========================================================
   // declarations
   dch_frame_t frame;
   dch_mode_t mode;
   logic [7:0] idx, pec_idx, dc_idx;
   logic merge, recalc, bump, insert;
   logic [7:0] dly0, dly1, own_msb, wr_lsb, wr_msb;
   logic [4:0] enum_addr, slot;
   logic [7:0] rx_crc, tx_crc, summary;
   logic body_byte, cmd_byte, uni_match, insert_now, own_byte;
   logic [7:0] src, next_tx_data;
   logic pec_check, pec_bad, pec_good, tx_crc_step, rx_crc_step;

   // ==========================================================
   // byte classification
   assign body_byte = rx_valid && !rx_preamble && !rx_stop && (frame == FR_BODY);
   assign cmd_byte = rx_valid && !rx_preamble && !rx_stop && (frame == FR_CMD);
   assign uni_match = (rx_data[7:3] == device_address_field);
   assign slot = device_address_field - first_address_field;
   assign insert_now = insert || ((mode == MD_READ) && (idx == IDX_LSB) && reg_addr_ok);

   // ==========================================================
   // framing and byte index
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         frame <= FR_IDLE;
         idx <= IDX_CMD;
      end else if (rx_preamble) begin
         frame <= FR_CMD;
         idx <= IDX_CMD;
      end else if (rx_stop) begin
         frame <= FR_IDLE;
      end else if (cmd_byte) begin
         frame <= FR_BODY;
         idx <= IDX_REG;
      end else if (body_byte && (idx != IDX_NONE)) begin
         idx <= idx + 8'h01;
      end
   end

   // ==========================================================
   // command decode and per-packet handling flags
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mode <= MD_PASS;
         merge <= 1'b0;
         recalc <= 1'b0;
         bump <= 1'b0;
         insert <= 1'b0;
         pec_idx <= IDX_NONE;
         dc_idx <= IDX_NONE;
      end else if (rx_preamble) begin
         mode <= MD_PASS;
         merge <= 1'b0;
         recalc <= 1'b0;
         bump <= 1'b0;
         insert <= 1'b0;
         pec_idx <= IDX_NONE;
         dc_idx <= IDX_NONE;
      end else if (cmd_byte) begin
         if ((rx_data == CMD_ENUMERATE) && address_unlock) begin
            mode <= MD_ENUM;
         end else if (rx_data == CMD_BCAST_WRITE) begin
            mode <= MD_WRITE;
            bump <= 1'b1;
            pec_idx <= IDX_WR_PEC;
         end else if ((rx_data[2:0] == CMD_UNI_WRITE_LOW) && uni_match) begin
            mode <= MD_WRITE;
            bump <= 1'b1;
            pec_idx <= IDX_WR_PEC;
         end else if (rx_data == CMD_BCAST_READ) begin
            mode <= MD_READ;
            merge <= 1'b1;
            recalc <= 1'b1;
            bump <= 1'b1;
            dc_idx <= IDX_LSB + {2'b00, slot, 1'b0};
            pec_idx <= IDX_LSB + {2'b00, slot, 1'b0} + 8'h01;
         end else if ((rx_data[2:0] == CMD_UNI_READ_LOW) && uni_match) begin
            mode <= MD_READ;
            merge <= 1'b1;
            recalc <= 1'b1;
            bump <= 1'b1;
            dc_idx <= IDX_LSB;
            pec_idx <= IDX_MSB;
         end
      end else if (body_byte && (mode == MD_READ) && (idx == IDX_LSB)) begin
         if (reg_addr_ok) begin
            insert <= 1'b1;
         end else begin
            mode <= MD_PASS;
            merge <= 1'b0;
            recalc <= 1'b0;
         end
      end
   end

   // ==========================================================
   // register address, own read data and two-byte delay line
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_addr <= 8'h00;
      end else if (body_byte && (idx == IDX_REG)) begin
         reg_addr <= rx_data;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         dly0 <= 8'h00;
         dly1 <= 8'h00;
         own_msb <= 8'h00;
      end else if (body_byte && insert_now) begin
         dly1 <= dly0;
         dly0 <= rx_data;
         if (idx == IDX_LSB) begin
            own_msb <= reg_rd_data[15:8];
         end
      end
   end

   // ==========================================================
   // outgoing byte: insertion, data-check merge, check byte, alive
   always_comb begin
      own_byte = 1'b0;
      src = idx;
      next_tx_data = rx_data;
      if ((frame == FR_BODY) && insert_now) begin
         if (idx == IDX_LSB) begin
            own_byte = 1'b1;
            next_tx_data = reg_rd_data[7:0];
         end else if (idx == IDX_MSB) begin
            own_byte = 1'b1;
            next_tx_data = own_msb;
         end else begin
            src = idx - INSERT_SHIFT;
            next_tx_data = dly1;
         end
      end
      if ((frame == FR_BODY) && !own_byte) begin
         if (merge && (src == dc_idx)) begin
            next_tx_data = next_tx_data | summary;
         end
         if (recalc && (src == pec_idx)) begin
            next_tx_data = tx_crc;
         end
         if (bump && alive_counter_enable && (src == pec_idx + 8'h01)) begin
            next_tx_data = next_tx_data + 8'h01;
         end
         if ((mode == MD_ENUM) && upstack_path && (src == IDX_ENUM_ADDR)) begin
            next_tx_data = {rx_data[7:5], rx_data[4:0] + 5'h01};
         end
      end
   end

   // ==========================================================
   // check bytes, received and outgoing
   assign rx_crc_step = cmd_byte || (body_byte && (idx < pec_idx));
   assign tx_crc_step = cmd_byte || (body_byte && (own_byte || (src < pec_idx)));

   dch_crc8 #(
      .POLY(CRC_POLY)
   ) u_rx_crc (
      .mclk(mclk),
      .reset(reset),
      .clear(rx_preamble),
      .step(rx_crc_step),
      .din(rx_data),
      .crc(rx_crc)
   );

   dch_crc8 #(
      .POLY(CRC_POLY)
   ) u_tx_crc (
      .mclk(mclk),
      .reset(reset),
      .clear(rx_preamble),
      .step(tx_crc_step),
      .din(next_tx_data),
      .crc(tx_crc)
   );

   assign pec_check = body_byte && (pec_idx != IDX_NONE) && (idx == pec_idx) && !check_bypass;
   assign pec_bad = pec_check && (rx_data != rx_crc);
   assign pec_good = pec_check && (rx_data == rx_crc);

   dch_status u_status (
      .mclk(mclk),
      .reset(reset),
      .failure_mode_alert_one(failure_mode_alert_one),
      .failure_mode_alert_two(failure_mode_alert_two),
      .overvoltage_alert(overvoltage_alert),
      .undervoltage_alert(undervoltage_alert),
      .other_status_alert(other_status_alert),
      .pec_error(pec_bad),
      .check_error_alert_clear(check_error_alert_clear),
      .check_error_alert(check_error_alert),
      .summary(summary)
   );

   // ==========================================================
   // register writes
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_lsb <= 8'h00;
         wr_msb <= 8'h00;
      end else if (body_byte && (mode == MD_WRITE)) begin
         if (idx == IDX_LSB) begin
            wr_lsb <= rx_data;
         end
         if (idx == IDX_MSB) begin
            wr_msb <= rx_data;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_wr_en <= 1'b0;
         reg_wr_data <= 16'h0000;
      end else begin
         reg_wr_en <= 1'b0;
         if ((mode == MD_WRITE) && reg_addr_ok) begin
            if (pec_good || (rx_stop && (frame == FR_BODY) && check_bypass
                             && (idx > IDX_WR_PEC))) begin
               reg_wr_en <= 1'b1;
               reg_wr_data <= {wr_msb, wr_lsb};
            end
         end
      end
   end

   // ==========================================================
   // address enumeration and unlock
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         enum_addr <= RST_DEVICE_ADDRESS;
      end else if (body_byte && (mode == MD_ENUM) && (idx == IDX_ENUM_ADDR)) begin
         enum_addr <= rx_data[4:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         device_address_field <= RST_DEVICE_ADDRESS;
         address_unlock <= RST_ADDRESS_UNLOCK;
      end else if (rx_stop && (frame == FR_BODY) && (mode == MD_ENUM) && upstack_path
                   && (idx == ENUM_LEN)) begin
         device_address_field <= enum_addr;
         address_unlock <= 1'b0;
      end else if (address_unlock_set) begin
         address_unlock <= 1'b1;
      end
   end

   // ==========================================================
   // output stage, one cycle behind the input
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         tx_preamble <= 1'b0;
         tx_stop <= 1'b0;
      end else begin
         tx_preamble <= rx_preamble;
         tx_stop <= rx_stop && !rx_preamble;
         tx_valid <= rx_valid && !rx_preamble && !rx_stop;
         if (rx_valid && !rx_preamble && !rx_stop) begin
            tx_data <= next_tx_data;
         end
      end
   end

endmodule

`default_nettype wire

// ### tb/dch_packet_handler_checker.sv
// port assertions for the packet handler
`default_nettype none

module dch_packet_handler_checker import dch_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic rx_valid,
   input wire logic rx_preamble,
   input wire logic rx_stop,
   input wire logic tx_valid,
   input wire logic tx_preamble,
   input wire logic tx_stop,
   input wire logic check_bypass,
   input wire logic address_unlock_set,
   input wire logic check_error_alert_clear,
   input wire logic reg_addr_ok,
   input wire logic reg_wr_en,
   input wire logic [4:0] device_address_field,
   input wire logic address_unlock,
   input wire logic check_error_alert
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // ==========================================================
   // framing and bytes
   property p_pre;
      rx_preamble |=> tx_preamble;
   endproperty
   a_pre: assert property (p_pre) else $error("preamble not forwarded");
   property p_stop;
      rx_stop && !rx_preamble |=> tx_stop;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not forwarded");
   property p_byte;
      tx_valid |-> $past(rx_valid) && !$past(rx_stop) && !$past(rx_preamble);
   endproperty
   a_byte: assert property (p_byte) else $error("byte sent without received byte");
   // ==========================================================
   // register writes
   property p_wr;
      reg_wr_en |-> reg_addr_ok && $past(rx_valid || rx_stop);
   endproperty
   a_wr: assert property (p_wr) else $error("write at wrong place");
   property p_wr_chk;
      reg_wr_en && !check_bypass |-> $past(rx_valid) && !$past(rx_stop);
   endproperty
   a_wr_chk: assert property (p_wr_chk) else $error("checked write not after check byte");
   // ==========================================================
   // enumeration and alert
   property p_lock;
      $fell(address_unlock) |-> $past(rx_stop);
   endproperty
   a_lock: assert property (p_lock) else $error("unlock cleared outside stop");
   property p_unlock;
      $rose(address_unlock) |-> $past(address_unlock_set);
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock set without request");
   property p_da;
      $changed(device_address_field) |-> $past(address_unlock) && $past(rx_stop);
   endproperty
   a_da: assert property (p_da) else $error("address changed while locked");
   property p_alert;
      $rose(check_error_alert) |-> $past(rx_valid) && !check_bypass;
   endproperty
   a_alert: assert property (p_alert) else $error("alert without checked byte");
   property p_clr;
      $fell(check_error_alert) |-> $past(check_error_alert_clear);
   endproperty
   a_clr: assert property (p_clr) else $error("alert dropped without clear");
endmodule

bind dch_packet_handler dch_packet_handler_checker u_chk (.mclk(mclk), .reset(reset),
   .rx_valid(rx_valid), .rx_preamble(rx_preamble), .rx_stop(rx_stop), .tx_valid(tx_valid),
   .tx_preamble(tx_preamble), .tx_stop(tx_stop), .check_bypass(check_bypass),
   .address_unlock_set(address_unlock_set), .check_error_alert_clear(check_error_alert_clear),
   .reg_addr_ok(reg_addr_ok), .reg_wr_en(reg_wr_en), .device_address_field(device_address_field),
   .address_unlock(address_unlock), .check_error_alert(check_error_alert));

`default_nettype wire

// ### tb/dch_regmap_model.sv
// register map model on the far side of the packet handler
`default_nettype none

module dch_regmap_model import dch_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [15:0] reg_wr_data,
   output logic reg_addr_ok,
   output logic [15:0] reg_rd_data
);
   logic [15:0] mem [16];
   // ==========================================================
   // decode and read, unmapped shows inverted data
   assign reg_addr_ok = (reg_addr[7:4] == 4'h0);
   assign reg_rd_data = reg_addr_ok ? mem[reg_addr[3:0]] : ~mem[reg_addr[3:0]];
   // ==========================================================
   // write port
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 16; i++) begin
            mem[i] <= 16'h0000;
         end
      end else if (reg_wr_en && reg_addr_ok) begin
         mem[reg_addr[3:0]] <= reg_wr_data;
      end
   end
endmodule

`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the packet handler
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dch_pkg::*;
   logic mclk, reset, rx_valid, rx_preamble, rx_stop, tx_valid, tx_preamble, tx_stop;
   logic [7:0] rx_data, tx_data, reg_addr;
   logic upstack_path, alive_counter_enable, check_bypass, address_unlock_set;
   logic fm1, fm2, ov, uv, oth, clr, reg_addr_ok, reg_wr_en, address_unlock, check_error_alert;
   logic [4:0] first_address_field, device_address_field;
   logic [15:0] reg_rd_data, reg_wr_data;
   logic [15:0] sh [16];
   logic [7:0] pk[$];
   logic [7:0] ex[$];
   logic [24:0] wq[$];
   logic al;
   logic [31:0] seed = 32'h00000062;
   int num_errors = 0;
   int tests_run = 0;

   dch_packet_handler u_dut (.mclk(mclk), .reset(reset), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_preamble(rx_preamble), .rx_stop(rx_stop), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_preamble(tx_preamble), .tx_stop(tx_stop),
      .upstack_path(upstack_path), .alive_counter_enable(alive_counter_enable),
      .check_bypass(check_bypass), .first_address_field(first_address_field),
      .address_unlock_set(address_unlock_set), .failure_mode_alert_one(fm1),
      .failure_mode_alert_two(fm2), .overvoltage_alert(ov), .undervoltage_alert(uv),
      .other_status_alert(oth), .check_error_alert_clear(clr), .reg_addr(reg_addr),
      .reg_addr_ok(reg_addr_ok), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .device_address_field(device_address_field),
      .address_unlock(address_unlock), .check_error_alert(check_error_alert));
   dch_regmap_model u_map (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_addr_ok(reg_addr_ok),
      .reg_rd_data(reg_rd_data));

   // ==========================================================
   // clock, random source, check byte, compare
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] crc(input logic [7:0] b[$]);
      logic [7:0] c;
      c = 8'h00;
      foreach (b[i]) begin
         c = c ^ b[i];
         for (int j = 0; j < 8; j++) begin
            c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
         end
      end
      return c;
   endfunction
   function logic [7:0] st();
      return {al, fm1 | fm2, oth | al, 2'b00, ov, uv, 1'b0};
   endfunction
   task chk(input logic [24:0] e, input logic [24:0] a);
      tests_run++;
      if (a !== e) begin
         num_errors++;
         $display("MISMATCH at %0t: expected %h got %h", $time, e, a);
      end
   endtask
   task wrap_up();
      $display("compared %0d, mismatched %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ==========================================================
   // link driver and packet builders
   task send();
      @(negedge mclk) rx_preamble = 1'b1;
      @(negedge mclk) rx_preamble = 1'b0;
      repeat (2) @(negedge mclk);
      foreach (pk[i]) begin
         rx_data = pk[i];
         rx_valid = 1'b1;
         @(negedge mclk) rx_valid = 1'b0;
         rx_data = ~pk[i];
         repeat (2) @(negedge mclk);
      end
      rx_stop = 1'b1;
      @(negedge mclk) rx_stop = 1'b0;
      repeat (4) @(negedge mclk);
   endtask
   task enm(input logic [7:0] a, input logic [7:0] e);
      pk = {CMD_ENUMERATE, 8'h00, a};
      ex = {ex, CMD_ENUMERATE, 8'h00, e};
      send();
   endtask
   task wr(input logic [7:0] cmd, input logic [7:0] ra, input logic [15:0] d,
           input logic bad, input logic mine, input logic [7:0] a);
      pk = {cmd, ra, d[7:0], d[15:8]};
      pk.push_back(crc(pk) ^ {7'h00, bad});
      ex = {ex, pk};
      if (alive_counter_enable) begin
         pk.push_back(a);
         ex.push_back(a + {7'h00, mine});
      end
      if (mine && ra < 8'h10 && (check_bypass || !bad)) begin
         wq.push_back({1'b0, ra, d});
         sh[ra[3:0]] = d;
      end
      if (bad && mine && !check_bypass) al = 1'b1;
      send();
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] ra, input logic [7:0] dc,
                     input int k, input logic mine, input logic bc);
      logic [7:0] o[$];
      logic [7:0] up[$];
      logic [7:0] a;
      a = 8'(rnd());
      for (int i = 0; i < 2 * k; i++) up.push_back(8'(rnd()));
      pk = {cmd, ra, up, dc};
      pk.push_back(crc(pk));
      pk = {pk, a, 8'hc2, 8'hd3};
      if (mine && ra < 8'h10) begin
         o = {cmd, ra, sh[ra[3:0]][7:0], sh[ra[3:0]][15:8], up, dc | st()};
         o = {o, crc(o), a + 8'h01};
      end else begin
         o = pk;
         if (bc) o[o.size() - 3] = a + 8'h01;
      end
      ex = {ex, o};
      send();
   endtask

   // ==========================================================
   // output monitor
   always @(negedge mclk) begin
      if (tx_valid === 1'b1) begin
         if (ex.size() > 0) chk(ex.pop_front(), tx_data);
         else chk(25'h1000000, tx_data);
      end
      if (reg_wr_en === 1'b1) begin
         if (wq.size() > 0) chk(wq.pop_front(), {reg_addr, reg_wr_data});
         else chk(25'h1000000, {reg_addr, reg_wr_data});
      end
   end
   initial begin
      #400000;
      num_errors++;
      wrap_up();
   end

   // ==========================================================
   // scenarios
   initial begin
      {rx_valid, rx_preamble, rx_stop, alive_counter_enable, check_bypass} = 5'h00;
      {address_unlock_set, fm1, fm2, ov, uv, oth, clr, al} = 8'h00;
      rx_data = 8'h00;
      upstack_path = 1'b1;
      first_address_field = 5'h02;
      foreach (sh[i]) sh[i] = 16'h0000;
      reset = 1'b1;
      repeat (16) @(negedge mclk);
      reset = 1'b0;
      chk(1'h1, address_unlock);
      chk(5'h00, device_address_field);
      enm(8'h03, 8'h04);
      chk(5'h03, device_address_field);
      chk(1'h0, address_unlock);
      enm(8'h09, 8'h09);
      chk(5'h03, device_address_field);
      address_unlock_set = 1'b1;
      @(negedge mclk) address_unlock_set = 1'b0;
      chk(1'h1, address_unlock);
      upstack_path = 1'b0;
      enm(8'h07, 8'h07);
      upstack_path = 1'b1;
      chk(5'h03, device_address_field);
      $display("enumeration test done");
      alive_counter_enable = 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(CMD_BCAST_WRITE, 8'(i), 16'(rnd()), 1'b0, 1'b1,
            (i == 5) ? 8'hff : 8'(rnd()));
      end
      rd(CMD_BCAST_READ, 8'h02, 8'h00, 1, 1'b1, 1'b1);
      rd({5'h03, 3'h5}, 8'h05, 8'h00, 0, 1'b1, 1'b0);
      rd({5'h04, 3'h5}, 8'h05, 8'h00, 0, 1'b0, 1'b0);
      wr({5'h04, 3'h4}, 8'h01, 16'h1234, 1'b0, 1'b0, 8'h10);
      wr({5'h03, 3'h4}, 8'h01, 16'h5678, 1'b0, 1'b1, 8'h20);
      wr(CMD_BCAST_WRITE, 8'h40, 16'h1111, 1'b0, 1'b1, 8'h30);
      rd(CMD_BCAST_READ, 8'h40, 8'h00, 1, 1'b0, 1'b1);
      $display("read and write test done");
      wr(CMD_BCAST_WRITE, 8'h03, 16'hbeef, 1'b1, 1'b1, 8'h40);
      chk(1'h1, check_error_alert);
      rd(CMD_BCAST_READ, 8'h03, 8'h00, 1, 1'b1, 1'b1);
      clr = 1'b1;
      @(negedge mclk) clr = 1'b0;
      al = 1'b0;
      @(negedge mclk) chk(1'h0, check_error_alert);
      {fm2, ov, oth} = 3'h7;
      repeat (3) @(negedge mclk);
      rd(CMD_BCAST_READ, 8'h04, 8'h19, 1, 1'b1, 1'b1);
      {fm1, fm2, ov, uv, oth} = 5'h11;
      repeat (3) @(negedge mclk);
      rd(CMD_BCAST_READ, 8'h01, 8'h00, 1, 1'b1, 1'b1);
      $display("status test done");
      check_bypass = 1'b1;
      wr({5'h03, 3'h4}, 8'h06, 16'hcafe, 1'b1, 1'b1, 8'h50);
      chk(1'h0, check_error_alert);
      check_bypass = 1'b0;
      alive_counter_enable = 1'b0;
      wr(CMD_BCAST_WRITE, 8'h07, 16'h0f0f, 1'b0, 1'b1, 8'h00);
      alive_counter_enable = 1'b1;
      rd({5'h03, 3'h5}, 8'h06, 8'h00, 0, 1'b1, 1'b0);
      rd(CMD_BCAST_READ, 8'h07, 8'h00, 1, 1'b1, 1'b1);
      $display("bypass and alive test done");
      chk(25'h0, 25'(ex.size()));
      chk(25'h0, 25'(wq.size()));
      wrap_up();
   end
endmodule

`default_nettype wire
